// ### include/pwrseq_defines.vh
// timing counts and state codes of the carrier power sequencer
`ifndef PWRSEQ_DEFINES_VH
`define PWRSEQ_DEFINES_VH
`define CLK_FREQ_HZ        40000000
`define DEBOUNCE_TIME_US   10000
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define RAIL_SETTLE_TIME_US 100
`define RAIL_SETTLE_CYCLES ((`RAIL_SETTLE_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define CNT_WIDTH          20
`define ST_OFF             3'h0
`define ST_RAILS           3'h1
`define ST_WAIT_BTN        3'h2
`define ST_CARRIER         3'h3
`define ST_RUN             3'h4
`define ST_SUSPEND         3'h5
`define ST_SOFT_OFF        3'h6
`endif

// ### hw/carrier_power_sequencer.v
// power-up, reset and suspend sequencing of a module on a carrier board
`include "pwrseq_defines.vh"

// Contract
// - own power circuits stay off until input_power_bad_n reads high.
// - with own power up, the module watches for a power button event when one is used.
// - after the button step, carrier_standby_n is raised; carrier_power_enable is already high from the button wait on.
// - last of all the reset output is released and boot begins.
// - input_power_bad_n low means input voltage is not ready or out of range.
// - carrier_power_enable is active high and rises only once all own supplies are up.
// - carrier_power_enable follows resume_reset_n and stays active in soft-off and suspend.
// - carrier_standby_n goes low on suspend entry, when only power management and memory stay up.
// - a low reset request holds the module in reset during boot or resets it when running.
// - the reset request input has a pull-up so an undriven line reads inactive.
// - the reset output stays asserted through power-up and is released to begin booting.
// - a power button press wakes from soft-off or requests shutdown when running.
module carrier_power_sequencer #(
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter SETTLE_CYCLES   = `RAIL_SETTLE_CYCLES,
    parameter BUTTON_USED     = 1
) (
    input  wire CLOCK,
    input  wire NRST,
    input  wire INPUT_POWER_BAD_N,
    input  wire RESET_REQUEST_N,
    input  wire POWER_BUTTON_N,
    input  wire OWN_RAILS_GOOD,
    input  wire SUSPEND_TO_RAM_N,
    output reg  OWN_RAILS_ENABLE,
    output reg  CARRIER_POWER_ENABLE,
    output reg  CARRIER_STANDBY_N,
    output reg  RESET_OUT_N,
    output wire RESET_REQUEST_PULLUP,
    output wire [2:0] SEQ_STATE
);
    localparam [`CNT_WIDTH-1:0] DEB_MAX  = DEBOUNCE_CYCLES[`CNT_WIDTH-1:0];
    localparam [`CNT_WIDTH-1:0] SET_MAX  = SETTLE_CYCLES[`CNT_WIDTH-1:0];
    localparam [`CNT_WIDTH-1:0] CNT_ONE  = {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
    localparam [`CNT_WIDTH-1:0] CNT_ZERO = {`CNT_WIDTH{1'b0}};

    // state codes come from the header so the port checker decodes SEQ_STATE the same way
    localparam [2:0] S_OFF      = `ST_OFF;
    localparam [2:0] S_RAILS    = `ST_RAILS;
    localparam [2:0] S_WAIT_BTN = `ST_WAIT_BTN;
    localparam [2:0] S_CARRIER  = `ST_CARRIER;
    localparam [2:0] S_RUN      = `ST_RUN;
    localparam [2:0] S_SUSPEND  = `ST_SUSPEND;
    localparam [2:0] S_SOFT_OFF = `ST_SOFT_OFF;

    // shared by the debounce and settle counters; both are cleared or held before they could wrap
    function [`CNT_WIDTH-1:0] count_up;
        input [`CNT_WIDTH-1:0] value;
        begin
            count_up = value + CNT_ONE;
        end
    endfunction

    // a window of limit cycles is complete on its last count
    function window_done;
        input [`CNT_WIDTH-1:0] value;
        input [`CNT_WIDTH-1:0] limit;
        begin
            window_done = (value >= limit - CNT_ONE);
        end
    endfunction

    // carrier power stays on in soft-off and suspend, like a resume-reset line
    function carrier_on;
        input [2:0] st;
        begin
            case (st)
                S_WAIT_BTN, S_CARRIER, S_RUN, S_SUSPEND, S_SOFT_OFF: carrier_on = 1'b1;
                default:                                             carrier_on = 1'b0;
            endcase
        end
    endfunction

    // standby is low whenever the carrier may drop its unneeded rails
    function standby_up;
        input [2:0] st;
        begin
            case (st)
                S_CARRIER, S_RUN: standby_up = 1'b1;
                default:          standby_up = 1'b0;
            endcase
        end
    endfunction

    // only a running system is out of reset
    function boot_released;
        input [2:0] st;
        begin
            boot_released = (st == S_RUN);
        end
    endfunction

    // RESET_REQUEST_PULLUP enables the on-module pull-up resistor
    assign RESET_REQUEST_PULLUP = 1'b1;

    // idle-high pins reset high so the first edges after reset see no false request
    reg [1:0] pgood_sync_ff;
    reg [1:0] rreq_sync_ff;
    reg [1:0] btn_sync_ff;
    reg [1:0] rails_sync_ff;
    reg [1:0] s3_sync_ff;
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pgood_sync_ff <= 2'h0;
            rreq_sync_ff  <= 2'h3;
            btn_sync_ff   <= 2'h3;
            rails_sync_ff <= 2'h0;
            s3_sync_ff    <= 2'h3;
        end else begin
            pgood_sync_ff <= {pgood_sync_ff[0], INPUT_POWER_BAD_N};
            rreq_sync_ff  <= {rreq_sync_ff[0], RESET_REQUEST_N};
            btn_sync_ff   <= {btn_sync_ff[0], POWER_BUTTON_N};
            rails_sync_ff <= {rails_sync_ff[0], OWN_RAILS_GOOD};
            s3_sync_ff    <= {s3_sync_ff[0], SUSPEND_TO_RAM_N};
        end
    end
    wire input_power_ok = pgood_sync_ff[1];
    wire reset_request  = ~rreq_sync_ff[1];

    // button level must hold steady for the whole window before it counts
    reg [`CNT_WIDTH-1:0] deb_cnt_ff;
    reg                  btn_pressed_ff;
    reg                  btn_prev_ff;
    reg [`CNT_WIDTH-1:0] nxt_deb_cnt;
    reg                  nxt_btn_pressed;
    always @* begin
        nxt_deb_cnt     = CNT_ZERO;
        nxt_btn_pressed = btn_pressed_ff;
        if (~btn_sync_ff[1] != btn_pressed_ff) begin
            if (window_done(deb_cnt_ff, DEB_MAX))
                nxt_btn_pressed = ~btn_sync_ff[1];
            else
                nxt_deb_cnt = count_up(deb_cnt_ff);
        end
    end
    // one pulse per debounced press, so a held button never acts twice
    wire press_event = btn_pressed_ff & ~btn_prev_ff;
    wire rails_good  = rails_sync_ff[1];
    wire suspend_req = ~s3_sync_ff[1];

    reg [2:0]            state_ff;
    reg [2:0]            nxt_state;
    reg [`CNT_WIDTH-1:0] set_cnt_ff;
    reg [`CNT_WIDTH-1:0] nxt_set_cnt;
    wire                 settled = window_done(set_cnt_ff, SET_MAX);
    assign SEQ_STATE = state_ff;

    always @* begin
        nxt_state   = state_ff;
        nxt_set_cnt = CNT_ZERO;
        case (state_ff)
            S_OFF: begin
                if (input_power_ok)
                    nxt_state = S_RAILS;
            end
            S_RAILS: begin
                // the window restarts whenever the own rails drop out
                if (rails_good) begin
                    if (settled)
                        nxt_state = (BUTTON_USED != 0) ? S_WAIT_BTN : S_CARRIER;
                    else
                        nxt_set_cnt = count_up(set_cnt_ff);
                end
            end
            S_WAIT_BTN, S_SOFT_OFF: begin
                if (press_event)
                    nxt_state = S_CARRIER;
            end
            S_CARRIER: begin
                // reset held while carrier rails come up, then released
                if (!settled)
                    nxt_set_cnt = count_up(set_cnt_ff);
                else if (reset_request)
                    nxt_set_cnt = set_cnt_ff;
                else
                    nxt_state = S_RUN;
            end
            S_RUN: begin
                if (reset_request)
                    nxt_state = S_CARRIER;
                else if (press_event)
                    nxt_state = S_SOFT_OFF;
                else if (suspend_req)
                    nxt_state = S_SUSPEND;
            end
            S_SUSPEND: begin
                if (press_event || !suspend_req)
                    nxt_state = S_CARRIER;
            end
            default: nxt_state = S_OFF;
        endcase
        // losing input power aborts any state back to off
        if (!input_power_ok)
            nxt_state = S_OFF;
        // every state change starts its settle window from zero
        if (nxt_state != state_ff)
            nxt_set_cnt = CNT_ZERO;
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_ff             <= S_OFF;
            set_cnt_ff           <= CNT_ZERO;
            deb_cnt_ff           <= CNT_ZERO;
            btn_pressed_ff       <= 1'b0;
            btn_prev_ff          <= 1'b0;
            OWN_RAILS_ENABLE     <= 1'b0;
            CARRIER_POWER_ENABLE <= 1'b0;
            CARRIER_STANDBY_N    <= 1'b0;
            RESET_OUT_N          <= 1'b0;
        end else begin
            state_ff             <= nxt_state;
            set_cnt_ff           <= nxt_set_cnt;
            deb_cnt_ff           <= nxt_deb_cnt;
            btn_pressed_ff       <= nxt_btn_pressed;
            btn_prev_ff          <= btn_pressed_ff;
            OWN_RAILS_ENABLE     <= (nxt_state != S_OFF);
            // outputs decode the next state so they change on the same edge as SEQ_STATE
            CARRIER_POWER_ENABLE <= carrier_on(nxt_state);
            CARRIER_STANDBY_N    <= standby_up(nxt_state);
            RESET_OUT_N          <= boot_released(nxt_state);
        end
    end
endmodule // carrier_power_sequencer

// ### tb/carrier_power_sequencer_monitor.sv
// port checker of the carrier power sequencer
`include "pwrseq_defines.vh"
module carrier_power_sequencer_monitor (
    input wire logic       CLOCK,
    input wire logic       NRST,
    input wire logic       INPUT_POWER_BAD_N,
    input wire logic       RESET_REQUEST_N,
    input wire logic       POWER_BUTTON_N,
    input wire logic       OWN_RAILS_GOOD,
    input wire logic       SUSPEND_TO_RAM_N,
    input wire logic       OWN_RAILS_ENABLE,
    input wire logic       CARRIER_POWER_ENABLE,
    input wire logic       CARRIER_STANDBY_N,
    input wire logic       RESET_OUT_N,
    input wire logic       RESET_REQUEST_PULLUP,
    input wire logic [2:0] SEQ_STATE
);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // three samples cover the two sync flops plus the state edge
    sequence s_lost; !INPUT_POWER_BAD_N [*3]; endsequence
    sequence s_req; !RESET_REQUEST_N [*3] ##0 SEQ_STATE == `ST_RUN; endsequence
    property p_off; s_lost |=> !OWN_RAILS_ENABLE && !CARRIER_POWER_ENABLE; endproperty
    a_off: assert property (p_off) else $error("rails on without power");
    property p_cpe; CARRIER_POWER_ENABLE |-> OWN_RAILS_ENABLE; endproperty
    a_cpe: assert property (p_cpe) else $error("carrier power early");
    property p_stby; $rose(CARRIER_STANDBY_N) |-> CARRIER_POWER_ENABLE && SEQ_STATE == `ST_CARRIER; endproperty
    a_stby: assert property (p_stby) else $error("standby out of order");
    property p_boot; $rose(RESET_OUT_N) |-> $past(SEQ_STATE) == `ST_CARRIER && CARRIER_STANDBY_N; endproperty
    a_boot: assert property (p_boot) else $error("reset out of order");
    property p_req; s_req |=> !RESET_OUT_N; endproperty
    a_req: assert property (p_req) else $error("reset request lost");
    property p_susp; SEQ_STATE == `ST_SUSPEND |-> !CARRIER_STANDBY_N && CARRIER_POWER_ENABLE; endproperty
    a_susp: assert property (p_susp) else $error("bad suspend outputs");
    property p_soft; SEQ_STATE == `ST_SOFT_OFF |-> CARRIER_POWER_ENABLE && !RESET_OUT_N; endproperty
    a_soft: assert property (p_soft) else $error("bad soft-off outputs");
    property p_pull; RESET_REQUEST_PULLUP; endproperty
    a_pull: assert property (p_pull) else $error("pull-up off");
endmodule // carrier_power_sequencer_monitor
bind carrier_power_sequencer carrier_power_sequencer_monitor carrier_power_sequencer_monitor_i (
    .CLOCK                (CLOCK),
    .NRST                 (NRST),
    .INPUT_POWER_BAD_N    (INPUT_POWER_BAD_N),
    .RESET_REQUEST_N      (RESET_REQUEST_N),
    .POWER_BUTTON_N       (POWER_BUTTON_N),
    .OWN_RAILS_GOOD       (OWN_RAILS_GOOD),
    .SUSPEND_TO_RAM_N     (SUSPEND_TO_RAM_N),
    .OWN_RAILS_ENABLE     (OWN_RAILS_ENABLE),
    .CARRIER_POWER_ENABLE (CARRIER_POWER_ENABLE),
    .CARRIER_STANDBY_N    (CARRIER_STANDBY_N),
    .RESET_OUT_N          (RESET_OUT_N),
    .RESET_REQUEST_PULLUP (RESET_REQUEST_PULLUP),
    .SEQ_STATE            (SEQ_STATE)
);

// ### tb/carrier_supply_model.sv
// carrier supplies and reset line facing the sequencer
module carrier_supply_model (input wire logic clk, up, pull, en, pu, stby_n,
    output logic pbad_n = 1'b0, good = 1'b0, aux = 1'b0, output wire logic req_n);
    timeunit 1ns; timeprecision 1ps;
    logic [3:0] ramp = 4'h0;
    logic last = 1'b1;
    always @(posedge clk) begin
        ramp <= up ? ramp + {3'h0, ramp != 4'hF} : 4'h0;
        pbad_n <= ramp == 4'hF; // low until input stable
        good <= en && pbad_n;
        aux <= stby_n; // spare rails off in standby
        last <= req_n;
    end
    // released line without pull-up toggles, so a missing pull-up cannot pass by luck
    assign req_n = pull ? 1'b0 : pu ? 1'b1 : ~last;
endmodule // carrier_supply_model

// ### tb/carrier_power_sequencer_tb.sv
// self-checking bench of the carrier power sequencer
module carrier_power_sequencer_tb;
    timeunit 1ns; timeprecision 1ps;
    logic clock = 1'b0, nrst = 1'b0, up = 1'b0, pull = 1'b0, btn_n = 1'b1, susp_n = 1'b1;
    wire pbad_n, good, aux, req_n, en, cpe, stby_n, rst_n, pu;
    wire [2:0] st;
    int err_count = 0, checks_done = 0, seed = 56962, cycles = 0;
    always #12.5 clock = ~clock;
    carrier_supply_model carrier_supply_model_i (.clk(clock), .up(up), .pull(pull), .en(en), .pu(pu),
        .stby_n(stby_n), .pbad_n(pbad_n), .good(good), .aux(aux), .req_n(req_n));
    carrier_power_sequencer #(.DEBOUNCE_CYCLES(4), .SETTLE_CYCLES(4)) carrier_power_sequencer_i (.CLOCK(clock),
        .NRST(nrst), .INPUT_POWER_BAD_N(pbad_n), .RESET_REQUEST_N(req_n), .POWER_BUTTON_N(btn_n),
        .OWN_RAILS_GOOD(good), .SUSPEND_TO_RAM_N(susp_n), .OWN_RAILS_ENABLE(en), .CARRIER_POWER_ENABLE(cpe),
        .CARRIER_STANDBY_N(stby_n), .RESET_OUT_N(rst_n), .RESET_REQUEST_PULLUP(pu), .SEQ_STATE(st));
    task automatic close_out;
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            close_out;
        end
    end
    task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n); repeat (n) @(posedge clock); #1; endtask
    // rails, carrier power, standby_n, reset out
    function automatic logic [3:0] want(logic [2:0] s);
        return {s != 3'h0, s >= 3'h2, s == 3'h3 || s == 3'h4, s == 3'h4};
    endfunction
    task automatic reach(logic [2:0] s);
        for (int n = 0; n < 80 && st !== s; n++) cyc(1);
        chk("state", {1'b0, s}, {1'b0, st});
        chk("outputs", want(s), {en, cpe, stby_n, rst_n});
    endtask
    task automatic press(int len);
        @(posedge clock) btn_n <= 1'b0;
        repeat (len) @(posedge clock);
        btn_n <= 1'b1;
        // the debouncer must see the release before a following press can count
        repeat (8) @(posedge clock);
        #1;
    endtask
    initial begin
        cyc(20);
        chk("reset", 4'h0, {en, cpe, stby_n, rst_n});
        @(posedge clock) nrst <= 1'b1;
        cyc(10);
        chk("unpowered", 4'h0, {en, cpe, stby_n, rst_n});
        @(posedge clock) up <= 1'b1;
        reach(3'h2);
        press(1 + $unsigned($random(seed)) % 2);
        cyc(12);
        chk("glitch", 4'h2, {1'b0, st});
        press(20);
        reach(3'h4);
        @(posedge clock) susp_n <= 1'b0;
        reach(3'h5);
        cyc(1);
        chk("spare rails", 4'h0, {3'h0, aux});
        @(posedge clock) susp_n <= 1'b1;
        reach(3'h4);
        @(posedge clock) pull <= 1'b1;
        reach(3'h3);
        cyc(10 + $unsigned($random(seed)) % 8);
        chk("held", 4'h3, {1'b0, st});
        @(posedge clock) pull <= 1'b0;
        reach(3'h4);
        press(8 + $unsigned($random(seed)) % 8);
        reach(3'h6);
        press(8);
        reach(3'h4);
        @(posedge clock) nrst <= 1'b0;
        cyc(2);
        chk("mid reset", 4'h0, {en, cpe, stby_n, rst_n});
        @(posedge clock) nrst <= 1'b1;
        reach(3'h2);
        press(8);
        reach(3'h4);
        @(posedge clock) up <= 1'b0;
        reach(3'h0);
        close_out;
    end
endmodule // carrier_power_sequencer_tb
